// ### shared/dtd_pkg.sv
// Constants, types and helper functions shared by the data-transfer decoder and its register file
package dtd_pkg;

  // Operand sizes, also the shift amount that scales a displacement
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;

  // Top nibble of each transfer encoding
  localparam logic [3:0] OPC_IDX = 4'h0;
  localparam logic [3:0] OPC_STDISP = 4'h1;
  localparam logic [3:0] OPC_STIND = 4'h2;
  localparam logic [3:0] OPC_LDDISP = 4'h5;
  localparam logic [3:0] OPC_MOVREG = 4'h6;
  localparam logic [3:0] OPC_R0DISP = 4'h8;
  localparam logic [3:0] OPC_PCW = 4'h9;
  localparam logic [3:0] OPC_PCL = 4'hd;
  localparam logic [3:0] OPC_IMM = 4'he;

  // Sub-codes in the low nibble or the second nibble
  localparam logic [3:0] SUB_COPY = 4'h3;
  localparam logic [3:0] SUB_IDXB = 4'h4;
  localparam logic [3:0] R0D_STB = 4'h0;
  localparam logic [3:0] R0D_STW = 4'h1;
  localparam logic [3:0] R0D_LDB = 4'h4;
  localparam logic [3:0] R0D_LDW = 4'h5;

  // Register numbers and values
  localparam int NUM_REGS = 16;
  localparam logic [3:0] REG_ZERO = 4'h0;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] RST_INSN = 16'h0000;
  localparam logic [31:0] PC_ALIGN_MASK = 32'hffff_fffc;

  // Execute stage states
  typedef enum logic [2:0] {
    EX_IDLE = 3'b001,
    EX_RUN = 3'b010,
    EX_MEM = 3'b100
  } dtd_state_t;

  // One decoded transfer
  typedef struct packed {
    logic match;
    logic is_ld;
    logic is_st;
    logic is_imm;
    logic is_copy;
    logic pc_base;
    logic pc_align;
    logic use_idx;
    logic predec;
    logic wa_en;
    logic [1:0] size;
    logic [3:0] ra;
    logic [3:0] rb;
    logic [3:0] wa;
    logic [3:0] wb;
    logic [31:0] off;
    logic [31:0] immv;
  } dtd_dec_t;

  // Displacement scaled by operand size
  function automatic logic [31:0] dtd_scale(input logic [7:0] d, input logic [1:0] sz);
    return {24'h00_0000, d} << sz;
  endfunction

  // Byte count of an operand size
  function automatic logic [31:0] dtd_size_bytes(input logic [1:0] sz);
    return 32'h0000_0001 << sz;
  endfunction

  // Loaded bytes and words are sign-extended, longwords pass whole
  function automatic logic [31:0] dtd_sext(input logic [31:0] v, input logic [1:0] sz);
    case (sz)
      SZ_BYTE: return {{24{v[7]}}, v[7:0]};
      SZ_WORD: return {{16{v[15]}}, v[15:0]};
      default: return v;
    endcase
  endfunction

  // Full decode of one 16-bit instruction
  function automatic dtd_dec_t dtd_decode(input logic [15:0] i);
    dtd_dec_t d;
    logic [3:0] n;
    logic [3:0] m;
    logic [3:0] lo;
    d = '0;
    n = i[11:8];
    m = i[7:4];
    lo = i[3:0];
    case (i[15:12])
      OPC_IMM: begin
        d.match = 1'b1;
        d.is_imm = 1'b1;
        d.wa_en = 1'b1;
        d.wa = n;
        d.immv = {{24{i[7]}}, i[7:0]};
      end
      OPC_PCW, OPC_PCL: begin
        d.match = 1'b1;
        d.is_ld = 1'b1;
        d.pc_base = 1'b1;
        d.pc_align = (i[15:12] == OPC_PCL);
        d.size = (i[15:12] == OPC_PCL) ? SZ_LONG : SZ_WORD;
        d.wb = n;
        d.off = dtd_scale(i[7:0], d.size);
      end
      OPC_MOVREG: begin
        if (lo == SUB_COPY) begin
          d.match = 1'b1;
          d.is_copy = 1'b1;
          d.rb = m;
          d.wa_en = 1'b1;
          d.wa = n;
        end else if (!lo[3] && lo[1:0] != 2'h3) begin
          d.match = 1'b1;
          d.is_ld = 1'b1;
          d.size = lo[1:0];
          d.ra = m;
          d.wb = n;
          d.wa_en = lo[2];
          d.wa = m;
        end
      end
      OPC_STIND: begin
        if (!lo[3] && lo[1:0] != 2'h3) begin
          d.match = 1'b1;
          d.is_st = 1'b1;
          d.size = lo[1:0];
          d.ra = n;
          d.rb = m;
          d.predec = lo[2];
          d.wa_en = lo[2];
          d.wa = n;
        end
      end
      OPC_STDISP: begin
        d.match = 1'b1;
        d.is_st = 1'b1;
        d.size = SZ_LONG;
        d.ra = n;
        d.rb = m;
        d.off = dtd_scale({4'h0, lo}, SZ_LONG);
      end
      OPC_LDDISP: begin
        d.match = 1'b1;
        d.is_ld = 1'b1;
        d.size = SZ_LONG;
        d.ra = m;
        d.wb = n;
        d.off = dtd_scale({4'h0, lo}, SZ_LONG);
      end
      OPC_R0DISP: begin
        if (n == R0D_STB || n == R0D_STW || n == R0D_LDB || n == R0D_LDW) begin
          d.match = 1'b1;
          d.is_st = !n[2];
          d.is_ld = n[2];
          d.size = {1'b0, n[0]};
          d.ra = m;
          d.rb = REG_ZERO;
          d.wb = REG_ZERO;
          d.off = dtd_scale({4'h0, lo}, {1'b0, n[0]});
        end
      end
      OPC_IDX: begin
        if (lo == SUB_IDXB) begin
          d.match = 1'b1;
          d.is_st = 1'b1;
          d.size = SZ_BYTE;
          d.ra = n;
          d.rb = m;
          d.use_idx = 1'b1;
        end
      end
      default: d.match = 1'b0;
    endcase
    return d;
  endfunction

endpackage

// ### shared/dtd_rf_if.sv
// Register file read and write ports between the decoder core and its register file
`timescale 1ns/1ps
interface dtd_rf_if;
  logic [3:0] rd_a_sel;
  logic [3:0] rd_b_sel;
  logic [3:0] rd_c_sel;
  logic [3:0] rd_d_sel;
  logic [31:0] rd_a;
  logic [31:0] rd_b;
  logic [31:0] rd_c;
  logic [31:0] rd_d;
  logic wa_en;
  logic [3:0] wa_sel;
  logic [31:0] wa_data;
  logic wb_en;
  logic [3:0] wb_sel;
  logic [31:0] wb_data;

  modport core (
    output rd_a_sel, rd_b_sel, rd_c_sel, rd_d_sel, wa_en, wa_sel, wa_data, wb_en, wb_sel, wb_data,
    input rd_a, rd_b, rd_c, rd_d
  );
  modport rf (
    input rd_a_sel, rd_b_sel, rd_c_sel, rd_d_sel, wa_en, wa_sel, wa_data, wb_en, wb_sel, wb_data,
    output rd_a, rd_b, rd_c, rd_d
  );
endinterface

// ### logic/dtd_regfile.sv
// Sixteen general registers with two write ports and four registered read ports
`timescale 1ns/1ps
module dtd_regfile
  import dtd_pkg::*;
#(
  parameter int NREGS = NUM_REGS
) (
  input wire logic MCLK, // Core clock
  input wire logic RSTN, // Asynchronous reset, active low
  dtd_rf_if.rf rf        // Ports toward the core
);

  logic [31:0] regs_ff [NREGS];

  // Write-first read, so a value written this cycle is seen by the next stage
  function automatic logic [31:0] rd_fwd(input logic [3:0] sel);
    if (rf.wb_en && rf.wb_sel == sel) begin
      return rf.wb_data;
    end
    if (rf.wa_en && rf.wa_sel == sel) begin
      return rf.wa_data;
    end
    return regs_ff[sel];
  endfunction

  // Load data port wins over the address update when both hit one register
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int k = 0; k < NREGS; k++) begin
        regs_ff[k] <= RST_WORD;
      end
    end else begin
      if (rf.wa_en) begin
        regs_ff[rf.wa_sel] <= rf.wa_data;
      end
      if (rf.wb_en) begin
        regs_ff[rf.wb_sel] <= rf.wb_data;
      end
    end
  end

  // Registered read data
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      rf.rd_a <= RST_WORD;
      rf.rd_b <= RST_WORD;
      rf.rd_c <= RST_WORD;
      rf.rd_d <= RST_WORD;
    end else begin
      rf.rd_a <= rd_fwd(rf.rd_a_sel);
      rf.rd_b <= rd_fwd(rf.rd_b_sel);
      rf.rd_c <= rd_fwd(rf.rd_c_sel);
      rf.rd_d <= rd_fwd(rf.rd_d_sel);
    end
  end

endmodule

// ### logic/dtd_decoder.sv
// Data-transfer group decoder and executor with its own general register file
`timescale 1ns/1ps

module dtd_decoder
  import dtd_pkg::*;
(
  input wire logic MCLK,               // Core clock, 20 MHz
  input wire logic RSTN,               // Asynchronous reset, active low
  input wire logic INSN_VALID,         // Instruction offered
  input wire logic [15:0] INSN,        // Instruction word
  input wire logic [31:0] INSN_PC,     // Program counter as seen by this instruction
  output logic INSN_READY,             // Decoder takes an instruction this cycle
  input wire logic IFETCH_BUSY,        // Instruction fetch holds the bus this cycle
  output logic MEM_REQ,                // Data access request, held until acknowledge
  output logic MEM_WE,                 // Access is a store
  output logic [1:0] MEM_SIZE,         // Access size: byte, word, longword
  output logic [31:0] MEM_ADDR,        // Access address
  output logic [31:0] MEM_WDATA,       // Store data, low bits significant
  input wire logic MEM_ACK,            // Access finished this cycle
  input wire logic [31:0] MEM_RDATA,   // Load data, valid with acknowledge
  output logic DONE,                   // Transfer retired, one-cycle pulse
  output logic PASS_VALID,             // Instruction handed to other decoders, pulse
  output logic [15:0] PASS_INSN,       // Instruction handed on
  input wire logic [3:0] DBG_SEL,      // Register to observe
  output logic [31:0] DBG_DATA         // Observed register content
);

  dtd_rf_if rf ();

  dtd_state_t state_ff, nxt_state;
  dtd_dec_t ex_ff, nxt_ex;
  logic [31:0] pc_ff, nxt_pc;
  logic ready_ff, nxt_ready;
  logic mem_req_ff, nxt_mem_req;
  logic mem_we_ff, nxt_mem_we;
  logic [1:0] mem_size_ff, nxt_mem_size;
  logic [31:0] mem_addr_ff, nxt_mem_addr;
  logic [31:0] mem_wdata_ff, nxt_mem_wdata;
  logic done_ff;
  logic pass_ff;
  logic [15:0] pass_insn_ff, nxt_pass_insn;
  logic [31:0] dbg_ff;

  // Decode of the offered instruction; privilege state is not consulted
  dtd_dec_t in_dec;
  wire accept = INSN_VALID && ready_ff;
  assign in_dec = dtd_decode(INSN);
  wire accept_xfer = accept && in_dec.match;
  wire accept_pass = accept && !in_dec.match;

  // Execute stage classification
  wire ex_mem = ex_ff.is_ld || ex_ff.is_st;
  wire in_run = (state_ff == EX_RUN);
  wire in_mem = (state_ff == EX_MEM);
  wire mem_done = in_mem && MEM_ACK;
  // A data access never starts while a fetch holds the bus
  wire issue = in_run && ex_mem && !IFETCH_BUSY;
  // Register-only transfers retire in the cycle after they are taken
  wire complete = (in_run && !ex_mem) || mem_done;

  // Address formation from registered operands
  wire [31:0] sz_bytes = dtd_size_bytes(ex_ff.size);
  wire [31:0] pc_val = ex_ff.pc_align ? (pc_ff & PC_ALIGN_MASK) : pc_ff;
  wire [31:0] base_val = ex_ff.pc_base ? pc_val : rf.rd_a;
  wire [31:0] idx_val = ex_ff.use_idx ? rf.rd_c : ex_ff.off;
  wire [31:0] dec_addr = rf.rd_a - sz_bytes;
  wire [31:0] ex_addr = ex_ff.predec ? dec_addr : base_val + idx_val;

  // Value for the register-update port
  wire [31:0] inc_addr = rf.rd_a + sz_bytes;
  wire [31:0] upd_val = ex_ff.predec ? dec_addr : inc_addr;
  wire [31:0] copy_val = ex_ff.is_copy ? rf.rd_b : upd_val;
  wire [31:0] alu_val = ex_ff.is_imm ? ex_ff.immv : copy_val;

  // Register file hookup; read selects hold the executing instruction while it stalls
  assign rf.rd_a_sel = accept_xfer ? in_dec.ra : ex_ff.ra;
  assign rf.rd_b_sel = accept_xfer ? in_dec.rb : ex_ff.rb;
  assign rf.rd_c_sel = REG_ZERO;
  assign rf.rd_d_sel = DBG_SEL;
  // Updates land only on retirement; the status register has no path from here
  assign rf.wa_en = complete && ex_ff.wa_en;
  assign rf.wa_sel = ex_ff.wa;
  assign rf.wa_data = alu_val;
  // Load data, sign-extended for byte and word
  assign rf.wb_en = mem_done && ex_ff.is_ld;
  assign rf.wb_sel = ex_ff.wb;
  assign rf.wb_data = dtd_sext(MEM_RDATA, ex_ff.size);

  dtd_regfile #(
    .NREGS(NUM_REGS)
  ) u_regfile (
    .MCLK(MCLK),
    .RSTN(RSTN),
    .rf(rf)
  );

  // Next state of the execute stage
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      EX_IDLE: begin
        nxt_state = accept_xfer ? EX_RUN : EX_IDLE;
      end
      EX_RUN: begin
        if (ex_mem) begin
          nxt_state = issue ? EX_MEM : EX_RUN;
        end else begin
          nxt_state = accept_xfer ? EX_RUN : EX_IDLE;
        end
      end
      EX_MEM: begin
        nxt_state = MEM_ACK ? EX_IDLE : EX_MEM;
      end
      default: nxt_state = EX_IDLE;
    endcase
  end

  // Instruction held in the execute stage
  assign nxt_ex = accept_xfer ? in_dec : ex_ff;
  assign nxt_pc = accept_xfer ? INSN_PC : pc_ff;

  // Ready only when the stage will be free at the end of the next cycle.
  // A load keeps it low until its data is written, so a reader of the
  // loaded register can never see the old value.
  wire nxt_is_mem = nxt_ex.is_ld || nxt_ex.is_st;
  assign nxt_ready = (nxt_state == EX_IDLE) || ((nxt_state == EX_RUN) && !nxt_is_mem);

  // Memory request stands from issue until acknowledge
  assign nxt_mem_req = issue ? 1'b1 : (mem_done ? 1'b0 : mem_req_ff);
  assign nxt_mem_we = issue ? ex_ff.is_st : mem_we_ff;
  assign nxt_mem_size = issue ? ex_ff.size : mem_size_ff;
  assign nxt_mem_addr = issue ? ex_addr : mem_addr_ff;
  assign nxt_mem_wdata = issue ? rf.rd_b : mem_wdata_ff;
  assign nxt_pass_insn = accept_pass ? INSN : pass_insn_ff;

  // Stage state and held instruction
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      state_ff <= EX_IDLE;
      ex_ff <= '0;
      pc_ff <= RST_WORD;
      ready_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ex_ff <= nxt_ex;
      pc_ff <= nxt_pc;
      ready_ff <= nxt_ready;
    end
  end

  // Data bus outputs
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      mem_req_ff <= 1'b0;
      mem_we_ff <= 1'b0;
      mem_size_ff <= SZ_BYTE;
      mem_addr_ff <= RST_WORD;
      mem_wdata_ff <= RST_WORD;
    end else begin
      mem_req_ff <= nxt_mem_req;
      mem_we_ff <= nxt_mem_we;
      mem_size_ff <= nxt_mem_size;
      mem_addr_ff <= nxt_mem_addr;
      mem_wdata_ff <= nxt_mem_wdata;
    end
  end

  // Retire and hand-on pulses, observation port
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      done_ff <= 1'b0;
      pass_ff <= 1'b0;
      pass_insn_ff <= RST_INSN;
      dbg_ff <= RST_WORD;
    end else begin
      done_ff <= complete;
      pass_ff <= accept_pass;
      pass_insn_ff <= nxt_pass_insn;
      dbg_ff <= rf.rd_d;
    end
  end

  // Outputs straight from flip-flops
  assign INSN_READY = ready_ff;
  assign MEM_REQ = mem_req_ff;
  assign MEM_WE = mem_we_ff;
  assign MEM_SIZE = mem_size_ff;
  assign MEM_ADDR = mem_addr_ff;
  assign MEM_WDATA = mem_wdata_ff;
  assign DONE = done_ff;
  assign PASS_VALID = pass_ff;
  assign PASS_INSN = pass_insn_ff;
  assign DBG_DATA = dbg_ff;

endmodule

// ### tb/dtd_decoder_properties.sv
// Port-level timing and decoding checks for the data-transfer decoder
`timescale 1ns/1ps
module dtd_decoder_properties
  import dtd_pkg::*;
(
  input wire logic MCLK, // Core clock
  input wire logic RSTN, // Reset, active low
  input wire logic INSN_VALID, // Instruction offered
  input wire logic [15:0] INSN, // Instruction word
  input wire logic [31:0] INSN_PC, // Instruction address
  input wire logic INSN_READY, // Take strobe
  input wire logic IFETCH_BUSY, // Fetch owns bus
  input wire logic MEM_REQ, // Data request
  input wire logic MEM_WE, // Store flag
  input wire logic [1:0] MEM_SIZE, // Access size
  input wire logic [31:0] MEM_ADDR, // Access address
  input wire logic [31:0] MEM_WDATA, // Store data
  input wire logic MEM_ACK, // Access done
  input wire logic DONE, // Retire pulse
  input wire logic PASS_VALID, // Hand-on pulse
  input wire logic [15:0] PASS_INSN // Handed-on word
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RSTN);

  // Take events and group of the offered word; groups outside the transfer set go elsewhere
  wire take = INSN_VALID && INSN_READY;
  wire [3:0] grp = INSN[15:12];
  wire pass_grp = grp == 4'h3 || grp == 4'h4 || grp == 4'h7 || (grp >= 4'ha && grp != OPC_PCL && grp != OPC_IMM);

  // Issue happens only when fetch leaves the bus in the execute cycle
  sequence pcl_issue;
    take && grp == OPC_PCL ##1 !IFETCH_BUSY;
  endsequence
  sequence pcw_issue;
    take && grp == OPC_PCW ##1 !IFETCH_BUSY;
  endsequence
  sequence stind_issue;
    take && grp == OPC_STIND && !INSN[3] && INSN[1:0] != 2'h3 ##1 !IFETCH_BUSY;
  endsequence

  imm_done_a: assert property (take && grp == OPC_IMM |=> !PASS_VALID ##1 DONE)
    else $error("immediate load did not retire in time");
  pass_on_a: assert property (take && pass_grp |=> PASS_VALID && PASS_INSN == $past(INSN))
    else $error("foreign instruction not handed on");
  ack_done_a: assert property (MEM_REQ && MEM_ACK |=> !MEM_REQ && DONE && INSN_READY)
    else $error("access end not followed by retire");
  req_hold_a: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_SIZE)
    && $stable(MEM_WE) && $stable(MEM_WDATA))
    else $error("data request changed before acknowledge");
  fetch_hold_a: assert property (!MEM_REQ && IFETCH_BUSY |=> !MEM_REQ)
    else $error("data request issued against a fetch");
  mem_ready_a: assert property (take && (grp == OPC_STDISP || grp == OPC_LDDISP) |=> !INSN_READY [*2])
    else $error("new instruction taken during memory transfer");
  pcl_addr_a: assert property (pcl_issue |=> MEM_REQ && !MEM_WE && MEM_SIZE == SZ_LONG
    && MEM_ADDR == ($past(INSN_PC, 2) & 32'hffff_fffc) + {22'h0, $past(INSN[7:0], 2), 2'h0})
    else $error("longword relative load address wrong");
  pcw_addr_a: assert property (pcw_issue |=> MEM_REQ && !MEM_WE && MEM_SIZE == SZ_WORD
    && MEM_ADDR == $past(INSN_PC, 2) + {23'h0, $past(INSN[7:0], 2), 1'b0})
    else $error("word relative load address wrong");
  st_kind_a: assert property (stind_issue |=> MEM_REQ && MEM_WE && MEM_SIZE == $past(INSN[1:0], 2))
    else $error("indirect store kind wrong");
endmodule

bind dtd_decoder dtd_decoder_properties i_dtd_decoder_properties (.MCLK(MCLK), .RSTN(RSTN),
  .INSN_VALID(INSN_VALID), .INSN(INSN), .INSN_PC(INSN_PC), .INSN_READY(INSN_READY),
  .IFETCH_BUSY(IFETCH_BUSY), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_SIZE(MEM_SIZE),
  .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK), .DONE(DONE),
  .PASS_VALID(PASS_VALID), .PASS_INSN(PASS_INSN));

// ### tb/dtd_decoder_tb.sv
// Self-checking bench for the data-transfer decoder
`timescale 1ns/1ps
module dtd_decoder_tb;
  logic mclk, rstn, insn_valid, ifetch_busy, mem_ack, cap_w;
  logic [15:0] insn;
  logic [31:0] insn_pc, mem_rdata, rdv, cap_a, cap_d;
  logic [3:0] dbg_sel;
  logic [1:0] cap_s;
  int ack_dly, wcnt, miscompares, total_checks;
  wire insn_ready, mem_req, mem_we, done, pass_valid;
  wire [1:0] mem_size;
  wire [31:0] mem_addr, mem_wdata, dbg_data;
  wire [15:0] pass_insn;

  dtd_decoder i_dtd_decoder (.MCLK(mclk), .RSTN(rstn), .INSN_VALID(insn_valid), .INSN(insn),
    .INSN_PC(insn_pc), .INSN_READY(insn_ready), .IFETCH_BUSY(ifetch_busy), .MEM_REQ(mem_req),
    .MEM_WE(mem_we), .MEM_SIZE(mem_size), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
    .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata), .DONE(done), .PASS_VALID(pass_valid),
    .PASS_INSN(pass_insn), .DBG_SEL(dbg_sel), .DBG_DATA(dbg_data));

  // 50 ns clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Data memory; idle read bus toggles so a stale value never passes for load data
  always @(posedge mclk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req === 1'b1 && mem_ack !== 1'b1) begin
      if (wcnt >= ack_dly) begin
        mem_ack <= 1'b1;
        mem_rdata <= rdv;
        cap_a <= mem_addr;
        cap_s <= mem_size;
        cap_w <= mem_we;
        cap_d <= mem_wdata;
        wcnt = 0;
      end else begin
        wcnt = wcnt + 1;
      end
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Offer a word and hold it until the take edge; caller lowers valid in the same step
  task automatic issue(input logic [15:0] i);
    int n;
    n = 0;
    insn_valid <= 1'b1;
    insn <= i;
    @(posedge mclk);
    while (insn_ready !== 1'b1 && n < 40) begin
      n++;
      @(posedge mclk);
    end
    chk("take", {31'h0, insn_ready}, 32'h1);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (done !== 1'b1 && n < 40);
    chk("done", {31'h0, done}, 32'h1);
  endtask

  task automatic rchk(input logic [3:0] r, input logic [31:0] e);
    dbg_sel <= r;
    repeat (3) @(posedge mclk);
    chk("reg", dbg_data, e);
  endtask

  // One memory transfer, judged by what the memory saw
  task automatic mop(input logic [15:0] i, input logic [31:0] a, input logic w, input logic [1:0] s,
    input logic [31:0] d);
    issue(i);
    insn_valid <= 1'b0;
    wait_done();
    chk("addr", cap_a, a);
    chk("size", {30'h0, cap_s}, {30'h0, s});
    chk("we", {31'h0, cap_w}, {31'h0, w});
    chk("wdata", w ? cap_d : 32'h0, d);
  endtask

  function automatic logic [31:0] ldv(input logic [1:0] s);
    return s == 2'h0 ? 32'hffff_ff80 : s == 2'h1 ? 32'h0000_5680 : 32'h1234_5680;
  endfunction

  function automatic logic [31:0] immv(input logic [3:0] n);
    return {{24{n[3]}}, n, 4'h4};
  endfunction

  // Immediates back to back into every register, then copy a negative value whole
  task automatic t_regs();
    for (int j = 0; j < 16; j++) begin
      issue({4'he, 4'(j), 4'(j), 4'h4});
    end
    insn_valid <= 1'b0;
    for (int j = 0; j < 16; j++) begin
      rchk(4'(j), immv(4'(j)));
    end
    issue(16'h6e83);
    insn_valid <= 1'b0;
    wait_done();
    rchk(4'he, 32'hffff_ff84);
  endtask

  // Stores of every form, memory answering promptly and slowly
  task automatic t_store();
    logic [31:0] a;
    a = 32'h44;
    for (int j = 0; j < 3; j++) begin
      ack_dly = j;
      mop(16'h2420 | 16'(j), 32'h44, 1'b1, 2'(j), 32'h24);
    end
    for (int j = 0; j < 3; j++) begin
      a = a - (32'h1 << j);
      mop(16'h2424 | 16'(j), a, 1'b1, 2'(j), 32'h24);
    end
    rchk(4'h4, 32'h3d);
    mop(16'h1523, 32'h60, 1'b1, 2'h2, 32'h24);
    mop(16'h8063, 32'h67, 1'b1, 2'h0, 32'h4);
    mop(16'h8163, 32'h6a, 1'b1, 2'h1, 32'h4);
    mop(16'h0734, 32'h78, 1'b1, 2'h0, 32'h34);
  endtask

  // Loads of every form with a negative byte and a positive word in the returned data
  task automatic t_load();
    logic [31:0] a;
    a = 32'hffff_ffa4;
    rdv = 32'h1234_5680;
    for (int j = 0; j < 3; j++) begin
      mop(16'h6190 | 16'(j), 32'hffff_ff94, 1'b0, 2'(j), 32'h0);
      rchk(4'h1, ldv(2'(j)));
      mop(16'h61a4 | 16'(j), a, 1'b0, 2'(j), 32'h0);
      rchk(4'h1, ldv(2'(j)));
      a = a + (32'h1 << j);
    end
    rchk(4'ha, a);
    mop(16'h5b72, 32'h7c, 1'b0, 2'h2, 32'h0);
    rchk(4'hb, ldv(2'h2));
    mop(16'h8473, 32'h77, 1'b0, 2'h0, 32'h0);
    rchk(4'h0, ldv(2'h0));
    mop(16'h8573, 32'h7a, 1'b0, 2'h1, 32'h0);
    rchk(4'h0, ldv(2'h1));
    mop(16'hdc05, 32'h1014, 1'b0, 2'h2, 32'h0);
    rchk(4'hc, ldv(2'h2));
    mop(16'h9d05, 32'h100c, 1'b0, 2'h1, 32'h0);
    rchk(4'hd, ldv(2'h1));
  endtask

  // Fetch holds the bus, then a load feeds the very next copy
  task automatic t_stall();
    ifetch_busy <= 1'b1;
    issue(16'h2422);
    insn_valid <= 1'b0;
    repeat (6) begin
      @(posedge mclk);
      chk("req", {31'h0, mem_req}, 32'h0);
    end
    ifetch_busy <= 1'b0;
    wait_done();
    chk("addr", cap_a, 32'h3d);
    ack_dly = 3;
    issue(16'h6222);
    issue(16'h6323);
    insn_valid <= 1'b0;
    wait_done();
    rchk(4'h3, ldv(2'h2));
  endtask

  // Words outside the group, including near misses, are handed on untouched
  task automatic t_pass();
    logic [15:0] ops [5] = '{16'h3abc, 16'h6218, 16'h2213, 16'h0215, 16'h8212};
    foreach (ops[k]) begin
      issue(ops[k]);
      insn_valid <= 1'b0;
      @(posedge mclk);
      chk("pass", {31'h0, pass_valid}, 32'h1);
      chk("passed", {16'h0, pass_insn}, {16'h0, ops[k]});
      chk("req", {31'h0, mem_req}, 32'h0);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles the run needs
  initial begin
    repeat (5000) @(posedge mclk);
    miscompares++;
    wrap_up();
  end

  initial begin
    rstn = 1'b0;
    insn_valid = 1'b0;
    insn = 16'h0;
    insn_pc = 32'h0000_1002;
    ifetch_busy = 1'b0;
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
    dbg_sel = 4'h0;
    rdv = 32'h0;
    ack_dly = 0;
    wcnt = 0;
    miscompares = 0;
    total_checks = 0;
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_store();
    t_load();
    t_stall();
    t_pass();
    wrap_up();
  end
endmodule
